// File: common/dag_pkg.sv
package dag_pkg;
  localparam int PTR_W  = 12;
  localparam int DATA_W = 8;
  localparam int PAIRS  = 3;
  localparam int AV_ADDR_W = 14;

  // Register locations, one per SFR address; bus index equals SFR address
  localparam logic [11:0] PLAIN_ADDR_0   = 12'hfef;
  localparam logic [11:0] PLAIN_ADDR_1   = 12'hfe7;  // indirect_operand_one
  localparam logic [11:0] PLAIN_ADDR_2   = 12'hfdf;
  localparam logic [11:0] OFS_UP         = 12'h001;
  localparam logic [11:0] OFS_DOWN       = 12'h002;
  localparam logic [11:0] OFS_PRE        = 12'h003;
  localparam logic [11:0] OFS_ACC        = 12'h004;
  localparam logic [11:0] OFS_HI         = 12'h005;
  localparam logic [11:0] OFS_LO         = 12'h006;
  localparam logic [11:0] BANK_SEL_ADDR  = 12'hfe0;
  localparam logic [11:0] CFG_ADDR       = 12'hfd0;
  localparam logic [11:0] LAST_LO_ADDR   = 12'hfd1;
  localparam logic [11:0] LAST_HI_ADDR   = 12'hfd2;
  localparam int          CFG_EXT_BIT    = 0;

  // Address map limits and reset values
  localparam logic [7:0]  ILO_LIMIT      = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [11:0] PTR_RST        = 12'h000;
  localparam logic [3:0]  BANK_RST       = 4'h0;
  localparam logic        EXT_RST        = 1'b0;
  localparam logic [11:0] LAST_RST       = 12'h000;

  typedef enum logic [2:0] {DAG_OP_NONE, DAG_OP_PLAIN, DAG_OP_DOWN, DAG_OP_UP, DAG_OP_PRE, DAG_OP_ACC} dag_op_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] pair;
    dag_op_t    op;
  } dag_vop_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] pair;
    logic       hi;
  } dag_pbyte_t;

  function automatic logic [11:0] plain_addr(input logic [1:0] n);
    case (n)
      2'h0:    plain_addr = PLAIN_ADDR_0;
      2'h1:    plain_addr = PLAIN_ADDR_1;
      default: plain_addr = PLAIN_ADDR_2;
    endcase
  endfunction : plain_addr

  // Which virtual operand, if any, sits at an address
  function automatic dag_vop_t vop_decode(input logic [11:0] a);
    dag_vop_t   r;
    logic [1:0] nn;
    logic [11:0] b;
    r = '{hit: 1'b0, pair: 2'h0, op: DAG_OP_NONE};
    for (int n = 0; n < PAIRS; n++) begin
      nn = 2'(n);
      b  = plain_addr(nn);
      if (a == b) r = '{hit: 1'b1, pair: nn, op: DAG_OP_PLAIN};
      if (a == 12'(b - OFS_UP)) r = '{hit: 1'b1, pair: nn, op: DAG_OP_UP};
      if (a == 12'(b - OFS_DOWN)) r = '{hit: 1'b1, pair: nn, op: DAG_OP_DOWN};
      if (a == 12'(b - OFS_PRE)) r = '{hit: 1'b1, pair: nn, op: DAG_OP_PRE};
      if (a == 12'(b - OFS_ACC)) r = '{hit: 1'b1, pair: nn, op: DAG_OP_ACC};
    end
    return r;
  endfunction : vop_decode

  // Which pointer byte, if any, sits at an address
  function automatic dag_pbyte_t pbyte_decode(input logic [11:0] a);
    dag_pbyte_t r;
    logic [1:0] nn;
    logic [11:0] b;
    r = '{hit: 1'b0, pair: 2'h0, hi: 1'b0};
    for (int n = 0; n < PAIRS; n++) begin
      nn = 2'(n);
      b  = plain_addr(nn);
      if (a == 12'(b - OFS_LO)) r = '{hit: 1'b1, pair: nn, hi: 1'b0};
      if (a == 12'(b - OFS_HI)) r = '{hit: 1'b1, pair: nn, hi: 1'b1};
    end
    return r;
  endfunction : pbyte_decode
endpackage : dag_pkg

// File: common/dag_ptr_if.sv
`timescale 1ns/10ps
interface dag_ptr_if;
  logic [11:0] value;
  logic        step_up;
  logic        step_down;
  logic        load_lo;
  logic        load_hi;
  logic [7:0]  load_data;
  modport unit (input step_up, input step_down, input load_lo, input load_hi, input load_data, output value);
  modport ctrl (output step_up, output step_down, output load_lo, output load_hi, output load_data, input value);
endinterface : dag_ptr_if

// File: design/dag_ptr_unit.sv
`timescale 1ns/10ps
module dag_ptr_unit (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  dag_ptr_if.unit  ptr
);
  logic [11:0] value_r;
  logic [11:0] value_nxt;

  // A byte load beats a step so a write through the own operand is stored plainly
  assign value_nxt = ptr.load_lo   ? {value_r[11:8], ptr.load_data} :
                     ptr.load_hi   ? {ptr.load_data[3:0], value_r[7:0]} :
                     ptr.step_up   ? 12'(value_r + 12'h001) :  // RULE_07
                     ptr.step_down ? 12'(value_r - 12'h001) :  // RULE_07
                     value_r;

  // Whole 12-bit pair, so low-byte wrap carries into the high nibble
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) value_r <= dag_pkg::PTR_RST;
    else if (ce) value_r <= value_nxt;
  end

  assign ptr.value = value_r;
endmodule : dag_ptr_unit

// File: design/dag_top.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
// What this block does
// RULE_01: After-step-down operand uses pointer, then decrements
// RULE_02: After-step-up operand uses pointer, then increments
// RULE_03: Before-step-up operand increments, then uses pointer
// RULE_04: Accumulator offset adds signed accumulator to pointer
// RULE_05: Accumulator offset changes neither accumulator nor pointer
// RULE_06: Plain operand uses pointer unchanged
// RULE_07: Steps act on whole pair with carry
// RULE_08: Pointer steps never touch status flags
// RULE_09: Indirect read of virtual operand returns zero
// RULE_10: Indirect write to virtual operand does nothing
// RULE_11: Write through own operand stores without stepping
// RULE_12: Pointer bytes are ordinary directly accessible registers
// RULE_13: Literal offset mode only when extended enable set
// RULE_14: Extended, access bank, file 5Fh or less
// RULE_15: Literal offset target is file plus pair two
// RULE_16: File 60h up maps to access RAM
// RULE_17: Bank-select mode uses bank register, any file
// RULE_18: Inherent and literal instructions unaffected by mode
// RULE_19: Pairs zero and one unaffected by mode
// RULE_20: Window spans pair two to plus 95
// RULE_21: Pair is two bytes, 12-bit address
// RULE_22: Banked address is bank register plus file
// RULE_23: Offset sums wrap within 12 bits
module dag_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output wire logic [31:0] avs_readdata,
  output wire logic        avs_waitrequest,
  input  wire logic        ex_valid,
  input  wire logic [7:0]  ex_file,
  input  wire logic        ex_access_bank,
  input  wire logic        ex_full,
  input  wire logic [11:0] ex_full_addr,
  input  wire logic        ex_write,
  input  wire logic [7:0]  ex_wdata,
  input  wire logic [7:0]  ex_accum,
  output wire logic        mem_req,
  output wire logic        mem_we,
  output wire logic [11:0] mem_addr,
  output wire logic [7:0]  mem_wdata,
  output wire logic        rd_local,
  output wire logic [7:0]  rd_data,
  output wire logic        done
);
  dag_ptr_if pif [dag_pkg::PAIRS] ();

  logic [11:0]         pp_val [dag_pkg::PAIRS];
  logic [3:0]          bank_r;
  logic                ext_en_r;
  logic [11:0]         last_r;
  logic                wait_r;
  logic [31:0]         rdata_r;
  logic                mem_req_r;
  logic                mem_we_r;
  logic [11:0]         mem_addr_r;
  logic [7:0]          mem_wdata_r;
  logic                rd_local_r;
  logic [7:0]          rd_data_r;
  logic                done_r;

  // Direct address forms
  wire logic           ilo_sel;
  wire logic [11:0]    acc_addr;
  wire logic [11:0]    bank_addr;
  wire logic [11:0]    ilo_addr;
  wire logic [11:0]    dir_addr;
  assign ilo_sel   = ext_en_r && !ex_full && !ex_access_bank && (ex_file <= dag_pkg::ILO_LIMIT); // RULE_13 RULE_14
  assign acc_addr  = (ex_file < dag_pkg::ACCESS_SPLIT) ? {dag_pkg::ACCESS_LO_BANK, ex_file}
                                                      : {dag_pkg::ACCESS_HI_BANK, ex_file};  // RULE_16
  assign bank_addr = {bank_r, ex_file};  // RULE_17 RULE_22
  assign ilo_addr  = 12'(pp_val[2] + {4'h0, ex_file});  // RULE_15 RULE_20 RULE_23
  // Full addresses ignore the bank register; literal offset only under the mode bit
  assign dir_addr  = ex_full ? ex_full_addr : ex_access_bank ? bank_addr : ilo_sel ? ilo_addr : acc_addr;

  // Indirect resolution through a virtual operand
  dag_pkg::dag_vop_t   src;
  dag_pkg::dag_vop_t   tgt_v;
  dag_pkg::dag_pbyte_t tgt_p;
  wire logic [11:0]    base;
  wire logic [11:0]    acc_sx;
  wire logic [11:0]    ind_addr;
  wire logic [11:0]    tgt_addr;
  assign src      = dag_pkg::vop_decode(dir_addr);
  assign base     = pp_val[src.pair];
  assign acc_sx   = {{4{ex_accum[7]}}, ex_accum};  // RULE_05
  assign ind_addr = (src.op == dag_pkg::DAG_OP_PRE) ? 12'(base + 12'h001) :  // RULE_03
                    (src.op == dag_pkg::DAG_OP_ACC) ? 12'(base + acc_sx) :   // RULE_04 RULE_23
                    base;  // RULE_01 RULE_02 RULE_06
  assign tgt_addr = src.hit ? ind_addr : dir_addr;
  assign tgt_v    = dag_pkg::vop_decode(tgt_addr);
  assign tgt_p    = dag_pkg::pbyte_decode(tgt_addr);

  // Special cases of pointers aimed at pointers
  wire logic           null_acc;
  wire logic           self_load;
  wire logic           bank_hit;
  wire logic           local_hit;
  assign null_acc  = src.hit && tgt_v.hit;  // RULE_09 RULE_10
  assign self_load = src.hit && ex_write && tgt_p.hit && (tgt_p.pair == src.pair);  // RULE_11
  assign bank_hit  = (tgt_addr == dag_pkg::BANK_SEL_ADDR);
  assign local_hit = null_acc || tgt_p.hit || bank_hit;

  // Bus side: index equals SFR address, data in the low byte
  wire logic           bus_req;
  wire logic           bus_go;
  wire logic           bus_wr_go;
  wire logic [11:0]    bus_idx;
  wire logic [7:0]     bus_byte;
  dag_pkg::dag_pbyte_t bus_p;
  assign bus_req   = avs_read || avs_write;
  assign bus_go    = bus_req && !wait_r;
  assign bus_wr_go = bus_go && avs_write && avs_byteenable[0];
  assign bus_idx   = avs_address[13:2];
  assign bus_byte  = avs_writedata[7:0];
  assign bus_p     = dag_pkg::pbyte_decode(bus_idx);

  // Per-pair commands; a core load wins over a bus load on the same pair
  wire logic [2:0] core_ld;
  wire logic [2:0] bus_ld;
  wire logic [2:0] stepping;
  wire logic       core_go;
  assign core_go = ce && ex_valid;
  for (genvar g = 0; g < dag_pkg::PAIRS; g++) begin : g_pair
    assign core_ld[g]  = ex_valid && ex_write && !null_acc && tgt_p.hit && (tgt_p.pair == 2'(g));  // RULE_12
    assign bus_ld[g]   = bus_wr_go && bus_p.hit && (bus_p.pair == 2'(g));
    assign stepping[g] = ex_valid && src.hit && (src.pair == 2'(g)) && !self_load;  // RULE_11 RULE_19
    // Steps feed only the pointer; no status flag leaves this block
    assign pif[g].step_up   = stepping[g] && (src.op == dag_pkg::DAG_OP_UP || src.op == dag_pkg::DAG_OP_PRE);  // RULE_02 RULE_03 RULE_08
    assign pif[g].step_down = stepping[g] && (src.op == dag_pkg::DAG_OP_DOWN);  // RULE_01 RULE_08
    assign pif[g].load_lo   = core_ld[g] ? !tgt_p.hi : (bus_ld[g] && !bus_p.hi);
    assign pif[g].load_hi   = core_ld[g] ? tgt_p.hi : (bus_ld[g] && bus_p.hi);
    assign pif[g].load_data = core_ld[g] ? ex_wdata : bus_byte;
    assign pp_val[g]        = pif[g].value;  // RULE_21
    dag_ptr_unit u_ptr (
      .mclk  (mclk),
      .rst_n (rst_n),
      .ce    (ce),
      .ptr   (pif[g])
    );
  end

  // Local read data for pointer bytes, bank register and virtual targets
  wire logic [7:0] pb_val;
  wire logic [7:0] local_rd;
  assign pb_val   = tgt_p.hi ? {4'h0, pp_val[tgt_p.pair][11:8]} : pp_val[tgt_p.pair][7:0];
  assign local_rd = null_acc ? 8'h00 : tgt_p.hit ? pb_val : {4'h0, bank_r};  // RULE_09

  // Bus read mux; unmapped and virtual indices read zero
  wire logic [7:0] bus_pb;
  wire logic [7:0] bus_rd;
  assign bus_pb = bus_p.hi ? {4'h0, pp_val[bus_p.pair][11:8]} : pp_val[bus_p.pair][7:0];
  assign bus_rd = bus_p.hit ? bus_pb :
                  (bus_idx == dag_pkg::BANK_SEL_ADDR) ? {4'h0, bank_r} :
                  (bus_idx == dag_pkg::CFG_ADDR)      ? {7'h00, ext_en_r} :
                  (bus_idx == dag_pkg::LAST_LO_ADDR)  ? last_r[7:0] :
                  (bus_idx == dag_pkg::LAST_HI_ADDR)  ? {4'h0, last_r[11:8]} : 8'h00;

  // Bank register: core write wins over a bus write in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) bank_r <= dag_pkg::BANK_RST;
    else if (core_go && ex_write && !null_acc && bank_hit) bank_r <= ex_wdata[3:0];
    else if (ce && bus_wr_go && bus_idx == dag_pkg::BANK_SEL_ADDR) bank_r <= bus_byte[3:0];
  end

  // Extended mode bit, software only; last target kept as status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_en_r <= dag_pkg::EXT_RST;
      last_r   <= dag_pkg::LAST_RST;
    end else if (ce) begin
      if (bus_wr_go && bus_idx == dag_pkg::CFG_ADDR) ext_en_r <= bus_byte[dag_pkg::CFG_EXT_BIT];  // RULE_13
      if (ex_valid) last_r <= tgt_addr;
    end
  end

  // Wait one cycle, and longer while the core is busy, so the core never stalls
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      wait_r <= !(bus_req && wait_r && !ex_valid);
      if (wait_r) rdata_r <= {24'h00_0000, bus_rd};
    end
  end

  // Core answer, one cycle after the request; inherent ops simply never arrive here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= dag_pkg::LAST_RST;
      mem_wdata_r <= 8'h00;
      rd_local_r  <= 1'b0;
      rd_data_r   <= 8'h00;
      done_r      <= 1'b0;
    end else if (ce) begin
      mem_req_r   <= ex_valid && !local_hit;  // RULE_10 RULE_18
      mem_we_r    <= ex_valid && !local_hit && ex_write;
      mem_addr_r  <= tgt_addr;
      mem_wdata_r <= ex_wdata;
      rd_local_r  <= ex_valid && !ex_write && local_hit;
      rd_data_r   <= local_rd;
      done_r      <= ex_valid;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign mem_req         = mem_req_r;
  assign mem_we          = mem_we_r;
  assign mem_addr        = mem_addr_r;
  assign mem_wdata       = mem_wdata_r;
  assign rd_local        = rd_local_r;
  assign rd_data         = rd_data_r;
  assign done            = done_r;

  // Checks on the resolved address and pointer updates
  wire logic chk;
  assign chk = core_go && src.hit && !bus_wr_go && !self_load && !(|core_ld);

  a_post_dec_step: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
    chk && src.op == dag_pkg::DAG_OP_DOWN |=> pp_val[$past(src.pair)] == 12'($past(base) - 12'h001)
      && ($past(null_acc) || mem_addr_r == $past(base))) else $error("post decrement wrong");
  a_post_inc_step: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
    chk && src.op == dag_pkg::DAG_OP_UP |=> pp_val[$past(src.pair)] == 12'($past(base) + 12'h001)
      && mem_addr_r == $past(base)) else $error("post increment wrong");
  a_pre_inc_addr: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
    chk && src.op == dag_pkg::DAG_OP_PRE |=> mem_addr_r == pp_val[$past(src.pair)]
      && mem_addr_r == 12'($past(base) + 12'h001)) else $error("pre increment wrong");
  a_acc_index_addr: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
    chk && src.op == dag_pkg::DAG_OP_ACC |=> mem_addr_r == 12'($past(base) + $past(acc_sx)))
    else $error("accumulator offset address wrong");
  a_acc_index_keep: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_05
    chk && (src.op == dag_pkg::DAG_OP_ACC || src.op == dag_pkg::DAG_OP_PLAIN) |=> pp_val[$past(src.pair)] == $past(base))
    else $error("pointer changed without step");
  a_null_read_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
    core_go && null_acc && !ex_write |=> rd_local_r && rd_data_r == 8'h00 && !mem_req_r)
    else $error("virtual read not zero");
  a_null_write_void: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
    core_go && null_acc && ex_write && !bus_wr_go |=> !mem_we_r && $stable(bank_r))
    else $error("virtual write had effect");
  a_self_load_plain: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_11
    core_go && self_load && !tgt_p.hi |=> pp_val[$past(src.pair)][7:0] == $past(ex_wdata))
    else $error("self write stepped");
  a_ilo_window: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_15
    core_go && ilo_sel && !src.hit |=> mem_addr_r == 12'($past(pp_val[2]) + {4'h0, $past(ex_file)}))
    else $error("literal offset address wrong");
  a_bank_direct: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_17
    core_go && !ex_full && ex_access_bank && !src.hit |=> mem_addr_r == {$past(bank_r), $past(ex_file)})
    else $error("banked address wrong");

  c_post_inc: cover property (@(posedge mclk) disable iff (!rst_n) chk && src.op == dag_pkg::DAG_OP_UP);
  c_null_read: cover property (@(posedge mclk) disable iff (!rst_n) core_go && null_acc && !ex_write);
  c_ilo_access: cover property (@(posedge mclk) disable iff (!rst_n) core_go && ilo_sel);
  c_bus_write: cover property (@(posedge mclk) disable iff (!rst_n) ce && bus_wr_go);
endmodule : dag_top

// File: testbench/dag_mem_model.sv
`timescale 1ns/10ps
// Data memory on the far side of the resolved address; it only sees what the block lets through
module dag_mem_model (
  input  wire logic        mclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [11:0] peek_addr,
  output var  logic [7:0]  peek_data,
  output var  int          n_writes
);
  logic [7:0] mem [4096];

  // Count every write so that a swallowed write can be told from a real one
  initial n_writes = 0;
  always @(posedge mclk) begin
    if (mem_req === 1'b1 && mem_we === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
      n_writes <= n_writes + 1;
    end
  end

  // Read-back port for the bench only
  assign peek_data = mem[peek_addr];
endmodule : dag_mem_model

// File: testbench/dag_top_tb.sv
`timescale 1ns/10ps
module dag_top_tb;
  typedef struct packed {
    logic bank; logic full; logic [11:0] fa; logic wr; logic [7:0] wd; logic [7:0] acc; logic ext;
    logic e_req; logic [11:0] e_addr; logic e_loc; logic [7:0] e_rd;
  } dag_row_t;
  // Pointers start at pair0 123h, pair1 0FFh, pair2 200h, bank 3
  localparam dag_row_t ROWS [18] = '{
    '{1'b0, 1'b0, 12'h0e6, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'h0ff, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0e5, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'h100, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0e4, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'h100, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0e3, 1'b0, 8'h00, 8'hfe, 1'b0, 1'b1, 12'h0fe, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0e3, 1'b0, 8'h00, 8'h7f, 1'b0, 1'b1, 12'h17f, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0e7, 1'b1, 8'h5a, 8'h00, 1'b0, 1'b1, 12'h100, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0ef, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'h123, 1'b0, 8'h00},
    '{1'b1, 1'b0, 12'h045, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'h345, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h060, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'h060, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h05f, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'h05f, 1'b0, 8'h00},
    '{1'b0, 1'b1, 12'habc, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 12'habc, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0e9, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 12'hfe9, 1'b1, 8'h23},
    '{1'b0, 1'b0, 12'h010, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 12'h210, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h05f, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 12'h25f, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h060, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 12'h060, 1'b0, 8'h00},
    '{1'b1, 1'b0, 12'h010, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 12'h310, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0ef, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 12'h123, 1'b0, 8'h00},
    '{1'b0, 1'b0, 12'h0e3, 1'b0, 8'h00, 8'h01, 1'b1, 1'b1, 12'h101, 1'b0, 8'h00}};
  localparam logic [11:0] RST_IDX [8] = '{12'hfe9, 12'hfea, 12'hfe1, 12'hfe2, 12'hfd9, 12'hfda, 12'hfe0, 12'hfd0};

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [13:0] avs_address = 14'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ex_valid = 1'b0;
  logic [7:0]  ex_file = 8'h00;
  logic        ex_access_bank = 1'b0;
  logic        ex_full = 1'b0;
  logic [11:0] ex_full_addr = 12'h000;
  logic        ex_write = 1'b0;
  logic [7:0]  ex_wdata = 8'h00;
  logic [7:0]  ex_accum = 8'h00;
  logic        mem_req, mem_we, rd_local, done;
  logic [11:0] mem_addr;
  logic [7:0]  mem_wdata, rd_data, peek_data, tmp;
  int          n_writes, n_errors = 0, n_checks = 0, wsave;

  dag_top dag_top_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ex_valid(ex_valid), .ex_file(ex_file),
    .ex_access_bank(ex_access_bank), .ex_full(ex_full), .ex_full_addr(ex_full_addr), .ex_write(ex_write),
    .ex_wdata(ex_wdata), .ex_accum(ex_accum), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .rd_local(rd_local), .rd_data(rd_data), .done(done));
  dag_mem_model dag_mem_model_i (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .peek_addr(12'h100), .peek_data(peek_data), .n_writes(n_writes));

  // 100 MHz core clock
  always #5 mclk = ~mclk;

  task automatic ck(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : ck

  // Register bus cycle; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd, input logic [3:0] be,
                     output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    if (n >= 50) ck(1'b0, "bus wait too long");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic set_ptr(input logic [11:0] base, input logic [11:0] v);
    bus(1'b1, base - 12'h006, v[7:0], 4'h1, tmp);
    bus(1'b1, base - 12'h005, {4'h0, v[11:8]}, 4'h1, tmp);
  endtask : set_ptr

  task automatic chk_ptr(input logic [11:0] base, input logic [11:0] v);
    logic [7:0] lo;
    bus(1'b0, base - 12'h006, 8'h00, 4'h1, lo);
    bus(1'b0, base - 12'h005, 8'h00, 4'h1, tmp);
    ck({tmp[3:0], lo} === v, "pointer value");
  endtask : chk_ptr

  // Core request; signals change right after an edge and the answer comes one edge later
  task automatic drv(input dag_row_t r);
    ex_valid <= 1'b1;
    ex_access_bank <= r.bank;
    ex_full <= r.full;
    ex_file <= r.fa[7:0];
    ex_full_addr <= r.fa;
    ex_write <= r.wr;
    ex_wdata <= r.wd;
    ex_accum <= r.acc;
  endtask : drv

  task automatic chk_row(input dag_row_t r);
    ck(done === 1'b1 && mem_req === r.e_req && mem_we === (r.e_req & r.wr), "request pulses");
    ck(rd_local === r.e_loc && (r.e_loc !== 1'b1 || rd_data === r.e_rd), "local read");
    ck(mem_addr === r.e_addr && (r.wr !== 1'b1 || !r.e_req || mem_wdata === r.wd), "target address");
  endtask : chk_row

  task automatic one(input dag_row_t r);
    @(posedge mclk);
    drv(r);
    @(posedge mclk);
    ex_valid <= 1'b0;
    #1;
    chk_row(r);
  endtask : one

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #300000;
    ck(1'b0, "watchdog expired");
    give_verdict();
  end

  initial begin
    dag_row_t a;
    repeat (8) @(posedge mclk);
    ck(avs_waitrequest === 1'b1 && done === 1'b0 && mem_req === 1'b0 && mem_addr === 12'h000, "reset outputs");
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (RST_IDX[i]) begin
      bus(1'b0, RST_IDX[i], 8'h00, 4'h1, tmp);
      ck(tmp === 8'h00, "register reset value");
    end
    set_ptr(dag_pkg::PLAIN_ADDR_0, 12'h123);
    set_ptr(dag_pkg::PLAIN_ADDR_1, 12'h0ff);
    set_ptr(dag_pkg::PLAIN_ADDR_2, 12'h200);
    bus(1'b1, dag_pkg::BANK_SEL_ADDR, 8'h03, 4'h1, tmp);
    // Table of ordinary accesses, mode switched when a row asks for it
    foreach (ROWS[i]) begin
      bus(1'b0, dag_pkg::CFG_ADDR, 8'h00, 4'h1, tmp);
      if (tmp[0] !== ROWS[i].ext) bus(1'b1, dag_pkg::CFG_ADDR, {7'h00, ROWS[i].ext}, 4'h1, tmp);
      one(ROWS[i]);
    end
    chk_ptr(dag_pkg::PLAIN_ADDR_1, 12'h100);
    ck(peek_data === 8'h5a, "indirect write stored");
    // Back-to-back steps across the low-byte carry
    set_ptr(dag_pkg::PLAIN_ADDR_1, 12'h1ff);
    a = ROWS[0];
    @(posedge mclk);
    drv(a);
    @(posedge mclk);
    drv(a);
    #1;
    a.e_addr = 12'h1ff;
    chk_row(a);
    @(posedge mclk);
    ex_valid <= 1'b0;
    #1;
    a.e_addr = 12'h200;
    chk_row(a);
    chk_ptr(dag_pkg::PLAIN_ADDR_1, 12'h201);
    // Pointer aimed at a virtual operand: read gives zero, write is dropped
    set_ptr(dag_pkg::PLAIN_ADDR_0, 12'hfe7);
    one('{1'b0, 1'b0, 12'h0ef, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 12'hfe7, 1'b1, 8'h00});
    wsave = n_writes;
    a = '{1'b0, 1'b0, 12'h0ef, 1'b1, 8'h77, 8'h00, 1'b0, 1'b0, 12'hfe7, 1'b0, 8'h00};
    one(a);
    @(posedge mclk);
    ck(n_writes == wsave, "virtual write reached memory");
    chk_ptr(dag_pkg::PLAIN_ADDR_1, 12'h201);
    // Pair 2 aimed at its own low byte: a write through its step operand is stored, no step
    set_ptr(dag_pkg::PLAIN_ADDR_2, 12'hfd9);
    one('{1'b0, 1'b0, 12'h0dd, 1'b1, 8'h34, 8'h00, 1'b1, 1'b0, 12'hfd9, 1'b0, 8'h00});
    chk_ptr(dag_pkg::PLAIN_ADDR_2, 12'hf34);
    // Offset sums wrap inside the 12-bit space
    set_ptr(dag_pkg::PLAIN_ADDR_2, 12'hff0);
    one('{1'b0, 1'b0, 12'h020, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 12'h010, 1'b0, 8'h00});
    set_ptr(dag_pkg::PLAIN_ADDR_1, 12'hfff);
    one('{1'b0, 1'b0, 12'h0e3, 1'b0, 8'h00, 8'h01, 1'b1, 1'b1, 12'h000, 1'b0, 8'h00});
    // Bus refusals: masked write, unmapped place
    bus(1'b1, dag_pkg::BANK_SEL_ADDR, 8'h05, 4'h0, tmp);
    bus(1'b0, dag_pkg::BANK_SEL_ADDR, 8'h00, 4'h1, tmp);
    ck(tmp === 8'h03, "masked bus write took effect");
    bus(1'b1, 12'h800, 8'h5a, 4'h1, tmp);
    bus(1'b0, 12'h800, 8'h00, 4'h1, tmp);
    ck(tmp === 8'h00, "unmapped read not zero");
    // Enable low: a core step request must leave every flop alone
    @(posedge mclk);
    ce <= 1'b0;
    drv(ROWS[0]);
    @(posedge mclk);
    ex_valid <= 1'b0;
    ce <= 1'b1;
    #1;
    ck(done === 1'b0 && mem_req === 1'b0, "request taken while frozen");
    chk_ptr(dag_pkg::PLAIN_ADDR_1, 12'hfff);
    // Reset in mid-run brings the pointers back to zero
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    chk_ptr(dag_pkg::PLAIN_ADDR_1, 12'h000);
    bus(1'b0, dag_pkg::BANK_SEL_ADDR, 8'h00, 4'h1, tmp);
    ck(tmp === 8'h00, "bank not reset");
    give_verdict();
  end
endmodule : dag_top_tb
